// ### rtl/power_accumulator.sv
// four-channel power accumulator with a serial-bus slave port
// assumes ADC results arrive on the CLK domain; bus and strap pins are asynchronous
`timescale 1ns/1ns
module power_accumulator #(
    parameter int TICK_CYCLES = power_acc_pkg::TICK_CYCLES,
    parameter int SLOW_FACTOR = power_acc_pkg::SLOW_FACTOR,
    parameter logic [7:0] DEVICE_ID = power_acc_pkg::DEVICE_ID_DEF
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic POWER_DOWN_N,
    input wire logic SLOW_IN,
    input wire logic [6:0] ADDR_SEL,
    output logic SAMPLE_REQ,
    output logic [1:0] SAMPLE_CH,
    input wire logic ADC_VALID,
    input wire logic [13:0] VOLT_SAMPLE,
    input wire logic [12:0] CUR_HI_SAMPLE,
    input wire logic [12:0] CUR_LO_SAMPLE
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int SW = $clog2(SLOW_FACTOR + 1);

    typedef enum logic [2:0] {S_IDLE, S_REQ, S_WAIT, S_ADD, S_XREAD, S_XWRITE} seq_e;
    typedef enum logic [2:0] {I_IDLE, I_ADDR, I_CMD, I_WDATA, I_ACK, I_TX, I_RACK} bus_e;

    // ==========================================================
    // decoding shared by acknowledge and readout
    function automatic logic [3:0] cmd_len(input logic [7:0] c);
        if (c == power_acc_pkg::CMD_UPDATE) return power_acc_pkg::LEN_NONE;
        if (c == power_acc_pkg::CMD_CTRL || c == power_acc_pkg::CMD_DID) begin
            return power_acc_pkg::LEN_BYTE;
        end
        if (c == power_acc_pkg::CMD_COUNT) return power_acc_pkg::LEN_COUNT;
        if (c >= power_acc_pkg::CMD_PWR1 && c <= power_acc_pkg::CMD_PWR4) begin
            return power_acc_pkg::LEN_PWR;
        end
        if (c >= power_acc_pkg::CMD_VOLT1 && c <= power_acc_pkg::CMD_VOLT4) begin
            return power_acc_pkg::LEN_VOLT;
        end
        return power_acc_pkg::LEN_BAD;
    endfunction

    // block reads lead with the byte count, then the value top byte first
    function automatic logic [7:0] get_byte(input logic [55:0] v, input logic [3:0] n,
                                            input logic [3:0] i);
        logic [5:0] sh;
        sh = {3'(n - i), 3'h0};
        if (n == power_acc_pkg::LEN_BAD) return power_acc_pkg::READ_FILL;
        if (n == power_acc_pkg::LEN_BYTE) return (i == 4'h0) ? v[7:0] : power_acc_pkg::READ_FILL;
        if (i == 4'h0) return {4'h0, n};
        if (i > n) return power_acc_pkg::READ_FILL;
        return 8'(v >> sh);
    endfunction

    // ==========================================================
    // pin synchronisers
    logic [10:0] pin_m_reg;
    logic [10:0] pin_s_reg;
    logic scl_d_reg;
    logic sda_d_reg;
    wire [10:0] pins = {ADDR_SEL, SLOW_IN, POWER_DOWN_N, SDA_IN, SCL_IN};

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pin_m_reg <= power_acc_pkg::PIN_RST;
            pin_s_reg <= power_acc_pkg::PIN_RST;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            pin_m_reg <= pins;
            pin_s_reg <= pin_m_reg;
            scl_d_reg <= pin_s_reg[0];
            sda_d_reg <= pin_s_reg[1];
        end
    end

    wire scl_s = pin_s_reg[0];
    wire sda_s = pin_s_reg[1];
    wire pdn_n_s = pin_s_reg[2];
    wire slow_s = pin_s_reg[3];
    wire [6:0] addr_s = pin_s_reg[10:4];
    wire rst = SYS_RST | ~pdn_n_s;
    wire scl_rise = scl_s & ~scl_d_reg;
    wire scl_fall = ~scl_s & scl_d_reg;
    wire bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // ==========================================================
    // state
    seq_e sst_reg;
    bus_e bst_reg;
    bus_e nxt_reg;
    logic [1:0] ch_reg;
    logic tick_pend_reg;
    logic upd_pend_reg;
    logic upd_req_reg;
    logic [29:0] prod_reg;
    logic [23:0] cnt_reg;
    logic [23:0] snap_cnt_reg;
    logic [55:0] snap_acc_reg [4];
    logic [13:0] volt_reg [4];
    logic ovf_reg;
    logic [7:0] ctrl_reg;
    logic ctrl_wr_reg;
    logic [6:0] addr_reg;
    logic addr_ok_reg;
    logic [TW-1:0] tick_cnt_reg;
    logic [SW-1:0] slow_cnt_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] sh_reg;
    logic byte_done_reg;
    logic host_ack_reg;
    logic [7:0] ptr_reg;
    logic [3:0] idx_reg;
    logic [55:0] rd_data;

    // ==========================================================
    // datapath
    wire cur_hi_ok = CUR_HI_SAMPLE < power_acc_pkg::HI_GAIN_LIMIT;
    wire [15:0] cur_val = cur_hi_ok ? {3'h0, CUR_HI_SAMPLE} : {CUR_LO_SAMPLE, 3'h0};
    wire [29:0] prod_w = {14'h0, cur_val} * {16'h0, VOLT_SAMPLE};
    wire [56:0] sum_w = {1'b0, rd_data} + {27'h0, prod_reg};
    wire [55:0] sat_w = sum_w[56] ? power_acc_pkg::ACC_MAX : sum_w[55:0];
    wire sat_evt = (sst_reg == S_ADD) & sum_w[56];
    wire acc_last = (sst_reg == S_ADD) & (ch_reg == 2'h3);
    wire xfer_last = (sst_reg == S_XWRITE) & (ch_reg == 2'h3);
    wire mem_wr = (sst_reg == S_ADD) | (sst_reg == S_XWRITE);
    wire [55:0] mem_wr_data = (sst_reg == S_ADD) ? sat_w : 56'h0;
    wire slow_eff = slow_s | ctrl_reg[power_acc_pkg::CTRL_SLOW_BIT];
    wire tick = tick_cnt_reg == TW'(TICK_CYCLES - 1);
    wire fire = tick & (~slow_eff | (slow_cnt_reg == SW'(SLOW_FACTOR - 1)));
    wire ovf_next = sat_evt | (ctrl_wr_reg ? (ovf_reg & ctrl_reg[0]) : ovf_reg);

    // one word per channel
    acc_mem #(.W(56), .DEPTH(4), .AW(2)) u_mem (
        .clk(CLK),
        .rst(rst),
        .wr_en(mem_wr),
        .wr_addr(ch_reg),
        .wr_data(mem_wr_data),
        .rd_addr(ch_reg),
        .rd_data(rd_data)
    );

    // ==========================================================
    // rate tick
    always_ff @(posedge CLK) begin
        if (rst) begin
            tick_cnt_reg <= '0;
            slow_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick ? '0 : TW'(tick_cnt_reg + 1'b1);
            if (tick) begin
                slow_cnt_reg <= (fire || !slow_eff) ? '0 : SW'(slow_cnt_reg + 1'b1);
            end
        end
    end

    // ==========================================================
    // sampling and accumulation sequencer
    always_ff @(posedge CLK) begin
        if (rst) begin
            sst_reg <= S_IDLE;
            ch_reg <= 2'h0;
            tick_pend_reg <= 1'b0;
            upd_pend_reg <= 1'b0;
            prod_reg <= '0;
            cnt_reg <= '0;
            snap_cnt_reg <= '0;
            SAMPLE_REQ <= 1'b0;
            ovf_reg <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                snap_acc_reg[i] <= '0;
                volt_reg[i] <= '0;
            end
        end else begin
            SAMPLE_REQ <= sst_reg == S_REQ;
            // a new request in the cycle a pending one retires is kept
            upd_pend_reg <= upd_req_reg | (upd_pend_reg & ~xfer_last);
            tick_pend_reg <= fire | (tick_pend_reg & ~acc_last);
            ovf_reg <= ovf_next;
            unique case (sst_reg)
                S_IDLE: begin
                    ch_reg <= 2'h0;
                    // a round in progress always finishes before a transfer
                    if (upd_pend_reg) begin
                        sst_reg <= S_XREAD;
                    end else if (tick_pend_reg) begin
                        sst_reg <= S_REQ;
                    end
                end
                S_REQ: sst_reg <= S_WAIT;
                S_WAIT: begin
                    if (ADC_VALID) begin
                        prod_reg <= prod_w;
                        volt_reg[ch_reg] <= VOLT_SAMPLE;
                        sst_reg <= S_ADD;
                    end
                end
                S_ADD: begin
                    if (ch_reg == 2'h3) begin
                        cnt_reg <= 24'(cnt_reg + 1'b1);
                        sst_reg <= S_IDLE;
                    end else begin
                        ch_reg <= 2'(ch_reg + 1'b1);
                        sst_reg <= S_REQ;
                    end
                end
                S_XREAD: sst_reg <= S_XWRITE;
                S_XWRITE: begin
                    snap_acc_reg[ch_reg] <= rd_data;
                    if (ch_reg == 2'h3) begin
                        snap_cnt_reg <= cnt_reg;
                        cnt_reg <= '0;
                        sst_reg <= S_IDLE;
                    end else begin
                        ch_reg <= 2'(ch_reg + 1'b1);
                        sst_reg <= S_XREAD;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // readout selection
    wire [3:0] ptr_len = cmd_len(ptr_reg);
    wire ptr_ok = ptr_len != power_acc_pkg::LEN_BAD;
    wire [1:0] pwr_idx = 2'(ptr_reg - power_acc_pkg::CMD_PWR1);
    wire [1:0] volt_idx = 2'(ptr_reg - power_acc_pkg::CMD_VOLT1);
    wire [55:0] sel_val =
        (ptr_reg == power_acc_pkg::CMD_CTRL) ? {48'h0, ctrl_reg[7:1], ovf_reg} :
        (ptr_reg == power_acc_pkg::CMD_DID) ? {48'h0, DEVICE_ID} :
        (ptr_reg == power_acc_pkg::CMD_COUNT) ? {32'h0, snap_cnt_reg} :
        (ptr_len == power_acc_pkg::LEN_PWR) ? snap_acc_reg[pwr_idx] :
        {40'h0, volt_reg[volt_idx], 2'h0};
    wire [7:0] tx_byte = get_byte(sel_val, ptr_len, idx_reg);
    wire addr_hit = addr_ok_reg & (sh_reg[7:1] == addr_reg);
    wire cmd_ok = cmd_len(sh_reg) != power_acc_pkg::LEN_BAD;
    wire byte_ack = (bst_reg == I_ADDR) ? addr_hit :
                    (bst_reg == I_CMD) ? cmd_ok : (ptr_reg == power_acc_pkg::CMD_CTRL);
    wire [3:0] idx_inc = (idx_reg == 4'hF) ? 4'hF : 4'(idx_reg + 1'b1);

    // ==========================================================
    // serial-bus slave
    always_ff @(posedge CLK) begin
        if (rst) begin
            bst_reg <= I_IDLE;
            nxt_reg <= I_IDLE;
            bit_cnt_reg <= 4'h0;
            sh_reg <= 8'h0;
            byte_done_reg <= 1'b0;
            host_ack_reg <= 1'b0;
            SDA_OE <= 1'b0;
            SDA_OUT <= 1'b0;
            ptr_reg <= power_acc_pkg::CMD_CTRL;
            idx_reg <= 4'h0;
            ctrl_reg <= power_acc_pkg::CTRL_RST;
            ctrl_wr_reg <= 1'b0;
            upd_req_reg <= 1'b0;
            addr_reg <= 7'h0;
            addr_ok_reg <= 1'b0;
        end else begin
            upd_req_reg <= 1'b0;
            ctrl_wr_reg <= 1'b0;
            SDA_OUT <= 1'b0;
            if (!addr_ok_reg) begin
                addr_reg <= addr_s;
                addr_ok_reg <= 1'b1;
            end
            if (bus_start) begin
                bst_reg <= I_ADDR;
                bit_cnt_reg <= 4'h0;
                byte_done_reg <= 1'b0;
                SDA_OE <= 1'b0;
            end else if (bus_stop) begin
                bst_reg <= I_IDLE;
                SDA_OE <= 1'b0;
            end else if (scl_rise) begin
                if (bst_reg == I_ADDR || bst_reg == I_CMD || bst_reg == I_WDATA) begin
                    sh_reg <= {sh_reg[6:0], sda_s};
                    bit_cnt_reg <= 4'(bit_cnt_reg + 1'b1);
                    byte_done_reg <= bit_cnt_reg == 4'h7;
                end else if (bst_reg == I_RACK) begin
                    host_ack_reg <= ~sda_s;
                    if (!sda_s) begin
                        idx_reg <= idx_inc;
                    end
                end
            end else if (scl_fall) begin
                if (byte_done_reg) begin
                    // ninth clock: acknowledge or leave the line released
                    byte_done_reg <= 1'b0;
                    bit_cnt_reg <= 4'h0;
                    bst_reg <= I_ACK;
                    SDA_OE <= byte_ack;
                    nxt_reg <= I_IDLE;
                    if (bst_reg == I_ADDR && addr_hit) begin
                        nxt_reg <= sh_reg[0] ? I_TX : I_CMD;
                        idx_reg <= 4'h0;
                    end else if (bst_reg == I_CMD) begin
                        ptr_reg <= sh_reg;
                        nxt_reg <= cmd_ok ? I_WDATA : I_IDLE;
                        upd_req_reg <= sh_reg == power_acc_pkg::CMD_UPDATE;
                    end else if (bst_reg == I_WDATA && ptr_reg == power_acc_pkg::CMD_CTRL) begin
                        ctrl_reg <= sh_reg;
                        ctrl_wr_reg <= 1'b1;
                    end
                end else if (bst_reg == I_ACK || (bst_reg == I_RACK && host_ack_reg)) begin
                    bst_reg <= (bst_reg == I_RACK) ? I_TX : nxt_reg;
                    SDA_OE <= (bst_reg == I_RACK || nxt_reg == I_TX) & ~tx_byte[7];
                    sh_reg <= {tx_byte[6:0], 1'b0};
                end else if (bst_reg == I_RACK) begin
                    bst_reg <= I_IDLE;
                end else if (bst_reg == I_TX) begin
                    if (bit_cnt_reg == 4'h7) begin
                        SDA_OE <= 1'b0;
                        bst_reg <= I_RACK;
                        bit_cnt_reg <= 4'h0;
                    end else begin
                        SDA_OE <= ~sh_reg[7];
                        sh_reg <= {sh_reg[6:0], 1'b0};
                        bit_cnt_reg <= 4'(bit_cnt_reg + 1'b1);
                    end
                end
            end
        end
    end

    assign SAMPLE_CH = ch_reg;

    // ==========================================================
    // checks
    default clocking @(posedge CLK); endclocking
    default disable iff (rst);

    sequence s_round_start;
        sst_reg == S_IDLE && tick_pend_reg && !upd_pend_reg;
    endsequence
    sequence s_xfer_end;
        sst_reg == S_XWRITE && ch_reg == 2'h3;
    endsequence

    property p_round;
        s_round_start |=> sst_reg == S_REQ ##1 SAMPLE_REQ && sst_reg == S_WAIT;
    endproperty
    a_round: assert property (p_round) else $error("round did not start");
    property p_prod;
        (sst_reg == S_WAIT && ADC_VALID) |=> prod_reg == 30'($past(cur_val) * $past(VOLT_SAMPLE));
    endproperty
    a_prod: assert property (p_prod) else $error("bad power product");
    property p_sat;
        (sst_reg == S_ADD && sum_w[56]) |-> mem_wr && mem_wr_data == power_acc_pkg::ACC_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("accumulator wrapped");
    property p_cur;
        !cur_hi_ok |-> cur_val == {CUR_LO_SAMPLE, 3'h0};
    endproperty
    a_cur: assert property (p_cur) else $error("wrong gain chosen");
    property p_xfer;
        s_xfer_end |=> cnt_reg == 24'h0 && snap_cnt_reg == $past(cnt_reg) && sst_reg == S_IDLE;
    endproperty
    a_xfer: assert property (p_xfer) else $error("update transfer wrong");
    property p_cnt;
        (sst_reg == S_ADD && ch_reg == 2'h3) |=> cnt_reg == 24'($past(cnt_reg) + 1'b1);
    endproperty
    a_cnt: assert property (p_cnt) else $error("round count wrong");
    property p_nack;
        (bst_reg == I_CMD && byte_done_reg && scl_fall && !cmd_ok && !bus_start && !bus_stop)
            |=> bst_reg == I_ACK && !SDA_OE;
    endproperty
    a_nack: assert property (p_nack) else $error("bad command acknowledged");
    property p_fill;
        !ptr_ok |-> tx_byte == power_acc_pkg::READ_FILL;
    endproperty
    a_fill: assert property (p_fill) else $error("fill byte wrong");
    property p_ptr;
        @(posedge CLK) disable iff (1'b0) SYS_RST |=> ptr_reg == power_acc_pkg::CMD_CTRL;
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer not at control");
    property p_pdn;
        @(posedge CLK) disable iff (SYS_RST) !pdn_n_s |=> !SDA_OE && bst_reg == I_IDLE;
    endproperty
    a_pdn: assert property (p_pdn) else $error("active while powered down");
    property p_addr;
        (addr_ok_reg && $past(addr_ok_reg)) |-> $stable(addr_reg);
    endproperty
    a_addr: assert property (p_addr) else $error("address changed");
endmodule

// ### rtl/power_acc_pkg.sv
// constants shared by the power accumulator and its accumulator memory
// assumes a 250 MHz system clock and four monitored channels
package power_acc_pkg;

    // ==========================================================
    // clock and accumulation rate
    localparam int CLK_HZ = 250_000_000;
    localparam int ACC_RATE_HZ = 1024;
    localparam int TICK_CYCLES = CLK_HZ / ACC_RATE_HZ;
    localparam int SLOW_FACTOR = 4;

    // ==========================================================
    // data widths
    localparam int NUM_CH = 4;
    localparam int CH_W = 2;
    localparam int ADC_W = 13;
    localparam int CUR_W = 16;
    localparam int VOLT_W = 14;
    localparam int PROD_W = 30;
    localparam int ACC_W = 56;
    localparam int CNT_W = 24;
    localparam int GAIN_SHIFT = 3;
    localparam logic [ADC_W-1:0] HI_GAIN_LIMIT = 13'h1F00;
    localparam logic [ACC_W-1:0] ACC_MAX = 56'hFF_FFFF_FFFF_FFFF;

    // ==========================================================
    // command codes and byte counts
    localparam logic [7:0] CMD_UPDATE = 8'h00;
    localparam logic [7:0] CMD_CTRL = 8'h01;
    localparam logic [7:0] CMD_COUNT = 8'h02;
    localparam logic [7:0] CMD_PWR1 = 8'h03;
    localparam logic [7:0] CMD_PWR4 = 8'h06;
    localparam logic [7:0] CMD_VOLT1 = 8'h07;
    localparam logic [7:0] CMD_VOLT4 = 8'h0A;
    localparam logic [7:0] CMD_DID = 8'h0F;
    localparam logic [3:0] LEN_NONE = 4'h0;
    localparam logic [3:0] LEN_BYTE = 4'h1;
    localparam logic [3:0] LEN_VOLT = 4'h2;
    localparam logic [3:0] LEN_COUNT = 4'h3;
    localparam logic [3:0] LEN_PWR = 4'h7;
    localparam logic [3:0] LEN_BAD = 4'hF;
    localparam logic [7:0] READ_FILL = 8'hFF;

    // ==========================================================
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam int CTRL_SLOW_BIT = 1;
    // arbitrary identification value
    localparam logic [7:0] DEVICE_ID_DEF = 8'h5A;
    // pin vector order: addr[6:0], slow, power_down_n, sda, scl
    localparam logic [10:0] PIN_RST = 11'h003;

endpackage

// ### rtl/acc_mem.sv
// per-channel accumulator storage with registered read data
// assumes one write and one read per cycle from the same clock
`timescale 1ns/1ns
module acc_mem #(
    parameter int W = power_acc_pkg::ACC_W,
    parameter int DEPTH = power_acc_pkg::NUM_CH,
    parameter int AW = power_acc_pkg::CH_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data
);
    logic [W-1:0] mem [DEPTH];

    // all words clear at reset so the first readout shows zeros
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
            rd_data <= '0;
        end else begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// ### dv/smbus_host.sv
// serial bus host model: start, stop and byte transfers on an open-drain pair
// assumes the bench resolves the wire as pulled up unless someone pulls it low
`timescale 1ns/1ns
module smbus_host (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // ==========================================================
    // bus primitives, 64 ns bit period
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // also serves as repeated start; leaves scl low
    // non-blocking updates: the bit grid lands on CLK edges, so this avoids a sampling race
    task automatic start_cond();
        sda_low <= 1'b0;
        #16 scl <= 1'b1;
        #16 sda_low <= 1'b1;
        #16 scl <= 1'b0;
        #16;
    endtask
    task automatic stop_cond();
        sda_low <= 1'b1;
        #16 scl <= 1'b1;
        #16 sda_low <= 1'b0;
        #32;
    endtask
    // sending a one releases the line, so the same bit serves transmit and receive
    task automatic bit_xfer(input logic b, output logic s);
        sda_low <= ~b;
        #16 scl <= 1'b1;
        #16 s = sda;
        #16 scl <= 1'b0;
        #16;
    endtask
    task automatic byte_xfer(input logic [7:0] tx, input logic ack_in,
                             output logic [7:0] rx, output logic ack_out);
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(tx[i], rx[i]);
        end
        bit_xfer(ack_in, ack_out);
    endtask
endmodule

// ### dv/tb.sv
// self-checking bench for the power accumulator: bus host, front-end model, table
// assumes the host model above and a short rate tick for simulation
`timescale 1ns/1ns
module tb;
    localparam int TICK = 200;
    localparam logic [6:0] ADDR = 7'h12;
    // arbitrary identification value
    localparam logic [7:0] ID = 8'h3C;
    typedef struct packed {logic [7:0] cmd; logic ack; logic [7:0] exp;} row_s;
    logic clk = 1'b0, rst = 1'b1, pdn_n = 1'b1, slow = 1'b0, adc_valid = 1'b0;
    logic scl, sda_low, sda_out, sda_oe, sample_req;
    logic [1:0] sample_ch, exp_ch = 2'h0;
    logic [12:0] hi = 13'h0000;
    logic [63:0] val, c;
    int failures = 0, checks_done = 0;
    wire sda = ~(sda_low | sda_oe);
    row_s rows[6] = '{'{8'h01, 1'b0, 8'h00}, '{8'h0F, 1'b0, ID}, '{8'h20, 1'b1, 8'hFF},
                      '{8'h07, 1'b0, 8'h02}, '{8'h03, 1'b0, 8'h07}, '{8'h02, 1'b0, 8'h03}};
    power_accumulator #(.TICK_CYCLES(TICK), .DEVICE_ID(ID)) power_accumulator_i (
        .CLK(clk), .SYS_RST(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .POWER_DOWN_N(pdn_n), .SLOW_IN(slow), .ADDR_SEL(ADDR),
        .SAMPLE_REQ(sample_req), .SAMPLE_CH(sample_ch), .ADC_VALID(adc_valid),
        .VOLT_SAMPLE(14'h0010), .CUR_HI_SAMPLE(hi), .CUR_LO_SAMPLE(13'h0002));
    smbus_host smbus_host_i (.scl(scl), .sda_low(sda_low), .sda(sda));
    initial begin
        forever #2 clk = ~clk;
    end
    // ==========================================================
    // checking and closing
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ==========================================================
    // front-end model: channel 1 sits at the high-gain clip so the low-gain path is used
    always @(posedge clk) begin
        adc_valid <= sample_req;
        hi <= (sample_ch == 2'h1) ? 13'h1F00 : 13'h0004;
        if (rst || !pdn_n) begin
            exp_ch <= 2'h0;
        end else if (sample_req) begin
            check("sample channel", sample_ch, exp_ch);
            exp_ch <= exp_ch + 2'h1;
        end
    end
    // ==========================================================
    // one bus transaction; with_cmd low reads at the current pointer
    task automatic xact(input logic with_cmd, input logic [7:0] cmd, input int n,
                        input logic a_ack, input logic c_ack, output logic [63:0] v);
        logic [7:0] rx;
        logic a;
        v = '0;
        smbus_host_i.start_cond();
        if (with_cmd) begin
            smbus_host_i.byte_xfer({ADDR, 1'b0}, 1'b1, rx, a);
            check("address ack", a, a_ack);
            smbus_host_i.byte_xfer(cmd, 1'b1, rx, a);
            check("command ack", a, c_ack);
            if (n > 0) smbus_host_i.start_cond();
        end
        if (n > 0) smbus_host_i.byte_xfer({ADDR, 1'b1}, 1'b1, rx, a);
        for (int i = 0; i < n; i++) begin
            smbus_host_i.byte_xfer(8'hFF, i == n - 1, rx, a);
            v = {v[55:0], rx};
        end
        smbus_host_i.stop_cond();
    endtask
    // write byte: address, command and one data byte; the data acknowledge is checked
    task automatic wr(input logic [7:0] cmd, input logic [7:0] d, input logic d_ack);
        logic [7:0] rx;
        logic a;
        smbus_host_i.start_cond();
        smbus_host_i.byte_xfer({ADDR, 1'b0}, 1'b1, rx, a);
        smbus_host_i.byte_xfer(cmd, 1'b1, rx, a);
        smbus_host_i.byte_xfer(d, 1'b1, rx, a);
        check("data ack", a, d_ack);
        smbus_host_i.stop_cond();
    endtask
    initial begin
        #200000 failures++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        xact(1'b0, 8'h00, 1, 1'b0, 1'b0, val);
        check("pointer after reset", val, 64'h00);
        foreach (rows[i]) begin
            xact(1'b1, rows[i].cmd, 1, 1'b0, rows[i].ack, val);
            check("row data", val, rows[i].exp);
        end
        wr(8'h01, 8'h80, 1'b0);
        xact(1'b1, 8'h01, 1, 1'b0, 1'b0, val);
        check("control readback", val, 64'h80);
        wr(8'h02, 8'h00, 1'b1);
        repeat (6 * TICK) @(posedge clk);
        // results are collected long before any total could saturate
        xact(1'b1, 8'h00, 0, 1'b0, 1'b0, val);
        repeat (2 * TICK) @(posedge clk);
        xact(1'b1, 8'h02, 4, 1'b0, 1'b0, val);
        c = {40'h0, val[23:0]};
        check("count length", val[31:24], 64'h03);
        check("count nonzero", c == 0, 64'h0);
        xact(1'b1, 8'h03, 8, 1'b0, 1'b0, val);
        check("ch1 energy", val[55:0], c * 64);
        xact(1'b1, 8'h04, 8, 1'b0, 1'b0, val);
        check("ch2 energy", val[55:0], c * 256);
        // slow pin: a window of about ten ticks holds only two or three rounds
        slow <= 1'b1;
        xact(1'b1, 8'h00, 0, 1'b0, 1'b0, val);
        repeat (8 * TICK) @(posedge clk);
        xact(1'b1, 8'h00, 0, 1'b0, 1'b0, val);
        repeat (2 * TICK) @(posedge clk);
        xact(1'b1, 8'h02, 4, 1'b0, 1'b0, val);
        check("slow count", val[23:0] > 24'h0 && val[23:0] < 24'h5, 64'h1);
        slow <= 1'b0;
        // power down only between rounds so the channel model stays in step
        @(posedge clk iff (sample_req && sample_ch == 2'h3));
        pdn_n <= 1'b0;
        repeat (10) @(posedge clk);
        xact(1'b1, 8'h01, 1, 1'b1, 1'b1, val);
        pdn_n <= 1'b1;
        repeat (20) @(posedge clk);
        xact(1'b0, 8'h00, 1, 1'b0, 1'b0, val);
        check("control after power-down", val, 64'h00);
        check("sda drive level", sda_out, 64'h0);
        complete_run();
    end
endmodule
